// *** hw/tsic_pkg.sv ***
// Operation
// - First serial request is receive OR transmit
// - Vectoring never clears serial request flags
// - Second serial port enable/level at bit 4
// - One level bit per source, 1 high
// - High preempts low; nothing preempts high
// - High level wins, then polling order
// - Fixed order ext0 serial2 timer0 ... timer2
// - Per-source enables, global gate blocks all
// - Source enable register bit layout
// - Extra enable register bit layout
// - Level register bit layout
// - Extra level register bit layout
// - Sample at sample phase, poll next cycle
// - Enabled set flag triggers hardware vector call
// - Call blocked by level, cycle, instruction
// - Blocked requests are not remembered
// - Call pushes counter only, loads vector
// - Fixed vector address per source
// - Return from isr clears current level
// - Plain return leaves in-progress set
// - External flag cleared only when edge mode
// - Timer0 and timer1 flags cleared on service
// - Timer2 flag never cleared by hardware
package tsic_pkg;

  // ****************************************************************
  // Register addresses and masks.
  // ****************************************************************
  localparam logic [7:0] EXTRA_ENABLE_ADDR = 8'hA7;
  localparam logic [7:0] SOURCE_ENABLE_ADDR = 8'hA8;
  localparam logic [7:0] EXTRA_LEVEL_ADDR = 8'hB7;
  localparam logic [7:0] LEVEL_SELECT_ADDR = 8'hB8;
  localparam logic [7:0] REG_RESET = 8'h00;
  localparam logic [7:0] SOURCE_ENABLE_MASK = 8'hBF;
  localparam logic [7:0] EXTRA_MASK = 8'h93;
  localparam logic [7:0] LEVEL_SELECT_MASK = 8'h3F;

  // ****************************************************************
  // Field positions.
  // ****************************************************************
  localparam int GLOBAL_GATE_BIT = 7;
  localparam int TIMER2_BIT = 5;
  localparam int SERIAL1_BIT = 4;
  localparam int TIMER1_BIT = 3;
  localparam int EXT1_BIT = 2;
  localparam int TIMER0_BIT = 1;
  localparam int EXT0_BIT = 0;
  localparam int DDC_BIT = 7;
  localparam int SERIAL2_BIT = 4;
  localparam int TWOWIRE_BIT = 1;
  localparam int USB_BIT = 0;

  // ****************************************************************
  // Sources in polling order, index 0 polled first.
  // ****************************************************************
  localparam int NUM_SRC = 10;
  localparam logic [3:0] SRC_EXT0 = 4'h0;
  localparam logic [3:0] SRC_SERIAL2 = 4'h1;
  localparam logic [3:0] SRC_TIMER0 = 4'h2;
  localparam logic [3:0] SRC_TWOWIRE = 4'h3;
  localparam logic [3:0] SRC_EXT1 = 4'h4;
  localparam logic [3:0] SRC_DDC = 4'h5;
  localparam logic [3:0] SRC_TIMER1 = 4'h6;
  localparam logic [3:0] SRC_USB = 4'h7;
  localparam logic [3:0] SRC_SERIAL1 = 4'h8;
  localparam logic [3:0] SRC_TIMER2 = 4'h9;

  // ****************************************************************
  // Vector addresses indexed by polling position.
  // ****************************************************************
  localparam logic [15:0] VECTOR_TABLE [NUM_SRC] = '{
    16'h0003, 16'h004B, 16'h000B, 16'h0043, 16'h0013,
    16'h003B, 16'h001B, 16'h0033, 16'h0023, 16'h002B
  };

  // ****************************************************************
  // Machine cycle: twelve clocks, sampling on the tenth phase slot.
  // ****************************************************************
  localparam logic [3:0] PHASES_PER_CYCLE = 4'hC;
  localparam logic [3:0] SAMPLE_PHASE = 4'h9;

  typedef enum logic [1:0] {
    TSIC_IDLE = 2'b00,
    TSIC_CALL = 2'b01
  } tsic_state_t;

  // Core-side instruction status for the current machine cycle.
  typedef struct packed {
    logic last_cycle;
    logic is_return_isr;
    logic is_plain_return;
    logic touches_int_regs;
  } tsic_core_t;

  // Raw request flags from the peripherals.
  typedef struct packed {
    logic ext0_request_flag;
    logic ext0_edge_select;
    logic ext1_request_flag;
    logic ext1_edge_select;
    logic timer0_overflow_flag;
    logic timer1_overflow_flag;
    logic timer2_overflow_flag;
    logic timer2_capture_flag;
    logic receive_request_flag;
    logic transmit_request_flag;
    logic serial2_request;
    logic twowire_request;
    logic ddc_request;
    logic usb_request;
  } tsic_flags_t;

endpackage

// *** hw/tsic_ctrl.sv ***
`timescale 1ns/1ps
module tsic_ctrl (
  input wire logic ref_clk,
  input wire logic resetn,
  input wire logic [7:0] sfr_addr,
  input wire logic sfr_wr,
  input wire logic [7:0] sfr_wdata,
  output logic [7:0] sfr_rdata,
  input wire tsic_pkg::tsic_core_t core,
  input wire tsic_pkg::tsic_flags_t flags,
  output logic hw_vector_call,
  output logic [15:0] vector_addr,
  output logic [3:0] vector_src,
  output logic ext0_flag_clear,
  output logic ext1_flag_clear,
  output logic timer0_flag_clear,
  output logic timer1_flag_clear,
  output logic low_in_progress,
  output logic high_in_progress,
  output logic machine_cycle_start
);

  // ****************************************************************
  // Registers and phase counter.
  // ****************************************************************
  logic [7:0] source_enable_q;
  logic [7:0] extra_enable_q;
  logic [7:0] level_select_q;
  logic [7:0] extra_level_q;
  logic [3:0] phase_q;
  logic [9:0] sample_q;
  logic [9:0] poll_q;
  logic low_q;
  logic high_q;
  tsic_pkg::tsic_state_t state_q;
  tsic_pkg::tsic_state_t state_d;
  logic call_q;
  logic [3:0] src_q;

  wire phase_end = (phase_q == tsic_pkg::PHASES_PER_CYCLE - 4'h1);
  wire sample_now = (phase_q == tsic_pkg::SAMPLE_PHASE);

  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      phase_q <= 4'h0;
    end else begin
      phase_q <= phase_end ? 4'h0 : phase_q + 4'h1;
    end
  end

  // ****************************************************************
  // Register access.
  // ****************************************************************
  wire wr_se = sfr_wr && (sfr_addr == tsic_pkg::SOURCE_ENABLE_ADDR);
  wire wr_xe = sfr_wr && (sfr_addr == tsic_pkg::EXTRA_ENABLE_ADDR);
  wire wr_ls = sfr_wr && (sfr_addr == tsic_pkg::LEVEL_SELECT_ADDR);
  wire wr_xl = sfr_wr && (sfr_addr == tsic_pkg::EXTRA_LEVEL_ADDR);

  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      source_enable_q <= tsic_pkg::REG_RESET;
      extra_enable_q <= tsic_pkg::REG_RESET;
      level_select_q <= tsic_pkg::REG_RESET;
      extra_level_q <= tsic_pkg::REG_RESET;
    end else begin
      if (wr_se) source_enable_q <= sfr_wdata & tsic_pkg::SOURCE_ENABLE_MASK;
      if (wr_xe) extra_enable_q <= sfr_wdata & tsic_pkg::EXTRA_MASK;
      if (wr_ls) level_select_q <= sfr_wdata & tsic_pkg::LEVEL_SELECT_MASK;
      if (wr_xl) extra_level_q <= sfr_wdata & tsic_pkg::EXTRA_MASK;
    end
  end

  assign sfr_rdata =
    (sfr_addr == tsic_pkg::SOURCE_ENABLE_ADDR) ? source_enable_q :
    (sfr_addr == tsic_pkg::EXTRA_ENABLE_ADDR) ? extra_enable_q :
    (sfr_addr == tsic_pkg::LEVEL_SELECT_ADDR) ? level_select_q :
    (sfr_addr == tsic_pkg::EXTRA_LEVEL_ADDR) ? extra_level_q : 8'h00;

  // ****************************************************************
  // Request vector, enables and levels in polling order.
  // ****************************************************************
  // serial OR
  wire serial1_req = flags.receive_request_flag | flags.transmit_request_flag;
  wire [9:0] raw_req = {
    flags.timer2_overflow_flag | flags.timer2_capture_flag,
    serial1_req, flags.usb_request, flags.timer1_overflow_flag,
    flags.ddc_request, flags.ext1_request_flag, flags.twowire_request,
    flags.timer0_overflow_flag, flags.serial2_request, flags.ext0_request_flag
  };
  wire [9:0] src_en = {
    source_enable_q[tsic_pkg::TIMER2_BIT], source_enable_q[tsic_pkg::SERIAL1_BIT],
    extra_enable_q[tsic_pkg::USB_BIT], source_enable_q[tsic_pkg::TIMER1_BIT],
    extra_enable_q[tsic_pkg::DDC_BIT], source_enable_q[tsic_pkg::EXT1_BIT],
    extra_enable_q[tsic_pkg::TWOWIRE_BIT], source_enable_q[tsic_pkg::TIMER0_BIT],
    extra_enable_q[tsic_pkg::SERIAL2_BIT], source_enable_q[tsic_pkg::EXT0_BIT]
  };
  wire [9:0] src_lvl = {
    level_select_q[tsic_pkg::TIMER2_BIT], level_select_q[tsic_pkg::SERIAL1_BIT],
    extra_level_q[tsic_pkg::USB_BIT], level_select_q[tsic_pkg::TIMER1_BIT],
    extra_level_q[tsic_pkg::DDC_BIT], level_select_q[tsic_pkg::EXT1_BIT],
    extra_level_q[tsic_pkg::TWOWIRE_BIT], level_select_q[tsic_pkg::TIMER0_BIT],
    extra_level_q[tsic_pkg::SERIAL2_BIT], level_select_q[tsic_pkg::EXT0_BIT]
  };

  // sample, poll next cycle
  // The samples move to the poll register at the end of the cycle in which they were taken,
  // so the decision at the end of the following cycle sees the previous cycle's samples.
  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      sample_q <= 10'h000;
      poll_q <= 10'h000;
    end else begin
      if (sample_now) sample_q <= raw_req;
      if (phase_end) poll_q <= sample_q;
    end
  end

  function automatic logic [4:0] tsic_first(input logic [9:0] v);
    logic [4:0] r;
    r = 5'h00;
    for (int i = tsic_pkg::NUM_SRC - 1; i >= 0; i--) begin
      if (v[i]) r = {1'b1, 4'(i)};
    end
    return r;
  endfunction

  wire [9:0] pend = poll_q & src_en & {10{source_enable_q[tsic_pkg::GLOBAL_GATE_BIT]}};
  wire [4:0] hi_pick = tsic_first(pend & src_lvl);
  wire [4:0] lo_pick = tsic_first(pend & ~src_lvl);
  wire pick_high = hi_pick[4];
  wire [3:0] pick_src = pick_high ? hi_pick[3:0] : lo_pick[3:0];
  wire pick_any = hi_pick[4] | lo_pick[4];

  wire level_ok = !high_q && (pick_high || !low_q);
  wire instr_ok = core.last_cycle && !core.is_return_isr && !core.touches_int_regs;
  // poll previous cycle's samples at cycle end only
  wire take = phase_end && pick_any && level_ok && instr_ok && (state_q == tsic_pkg::TSIC_IDLE);

  always_comb begin
    case (state_q)
      tsic_pkg::TSIC_IDLE: state_d = take ? tsic_pkg::TSIC_CALL : tsic_pkg::TSIC_IDLE;
      tsic_pkg::TSIC_CALL: state_d = tsic_pkg::TSIC_IDLE;
      default: state_d = tsic_pkg::TSIC_IDLE;
    endcase
  end

  // ****************************************************************
  // Call issue and in-progress tracking.
  // ****************************************************************
  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      state_q <= tsic_pkg::TSIC_IDLE;
      call_q <= 1'b0;
      src_q <= 4'h0;
      vector_addr <= 16'h0000;
      low_q <= 1'b0;
      high_q <= 1'b0;
    end else begin
      state_q <= state_d;
      call_q <= take;
      if (take) begin
        src_q <= pick_src;
        vector_addr <= tsic_pkg::VECTOR_TABLE[pick_src];
      end
      if (take && pick_high) begin
        high_q <= 1'b1;
      end else if (core.is_return_isr && core.last_cycle && phase_end) begin
        if (high_q) high_q <= 1'b0;
        else low_q <= 1'b0;
      end
      if (take && !pick_high) low_q <= 1'b1;
    end
  end

  assign hw_vector_call = call_q;
  assign vector_src = src_q;
  assign ext0_flag_clear = call_q && (src_q == tsic_pkg::SRC_EXT0) && flags.ext0_edge_select;
  assign ext1_flag_clear = call_q && (src_q == tsic_pkg::SRC_EXT1) && flags.ext1_edge_select;
  assign timer0_flag_clear = call_q && (src_q == tsic_pkg::SRC_TIMER0);
  assign timer1_flag_clear = call_q && (src_q == tsic_pkg::SRC_TIMER1);
  assign low_in_progress = low_q;
  assign high_in_progress = high_q;
  assign machine_cycle_start = (phase_q == 4'h0);

endmodule

// *** sim/tsic_sva.sv ***
`timescale 1ns/1ps
module tsic_sva (
  input logic ref_clk,
  input logic resetn,
  input logic [7:0] sfr_addr,
  input logic [7:0] sfr_rdata,
  input tsic_pkg::tsic_core_t core,
  input tsic_pkg::tsic_flags_t flags,
  input logic hw_vector_call,
  input logic [15:0] vector_addr,
  input logic [3:0] vector_src,
  input logic ext0_flag_clear,
  input logic ext1_flag_clear,
  input logic timer0_flag_clear,
  input logic timer1_flag_clear,
  input logic low_in_progress,
  input logic high_in_progress,
  input logic machine_cycle_start
);
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!resetn);
  property p_gap; hw_vector_call |=> !hw_vector_call [*8]; endproperty
  a_gap: assert property (p_gap) else $error("calls too close");
  property p_vec; hw_vector_call |-> vector_addr == tsic_pkg::VECTOR_TABLE[vector_src];
  endproperty
  a_vec: assert property (p_vec) else $error("wrong vector");
  property p_blk; hw_vector_call |-> !$past(high_in_progress) && $past(core.last_cycle);
  endproperty
  a_blk: assert property (p_blk) else $error("call while blocked");
  property p_ins; hw_vector_call |-> !$past(core.is_return_isr) && !$past(core.touches_int_regs);
  endproperty
  a_ins: assert property (p_ins) else $error("call after blocking instruction");
  property p_clr; ext0_flag_clear |-> hw_vector_call && vector_src == tsic_pkg::SRC_EXT0
    && flags.ext0_edge_select; endproperty
  a_clr: assert property (p_clr) else $error("bad ext0 clear");
  property p_t0; timer0_flag_clear |-> hw_vector_call && vector_src == tsic_pkg::SRC_TIMER0;
  endproperty
  a_t0: assert property (p_t0) else $error("bad timer0 clear");
  property p_x1; ext1_flag_clear |-> hw_vector_call && vector_src == tsic_pkg::SRC_EXT1
    && flags.ext1_edge_select; endproperty
  a_x1: assert property (p_x1) else $error("bad ext1 clear");
  property p_t1; timer1_flag_clear |-> hw_vector_call && vector_src == tsic_pkg::SRC_TIMER1;
  endproperty
  a_t1: assert property (p_t1) else $error("bad timer1 clear");
  property p_ret; $fell(low_in_progress) |-> $past(core.is_return_isr) && !$past(high_in_progress);
  endproperty
  a_ret: assert property (p_ret) else $error("low level dropped");
  property p_mcs; machine_cycle_start |-> ##12 machine_cycle_start; endproperty
  a_mcs: assert property (p_mcs) else $error("machine cycle length");
  property p_rsvd; sfr_addr == tsic_pkg::LEVEL_SELECT_ADDR |-> sfr_rdata[7:6] == 2'h0;
  endproperty
  a_rsvd: assert property (p_rsvd) else $error("reserved bits set");
endmodule

// *** sim/tsic_core_model.sv ***
`timescale 1ns/1ps
module tsic_core_model (
  input logic ref_clk,
  input logic resetn,
  input logic set_en,
  input tsic_pkg::tsic_flags_t set_val,
  input logic ext0_flag_clear,
  input logic ext1_flag_clear,
  input logic timer0_flag_clear,
  input logic timer1_flag_clear,
  output tsic_pkg::tsic_flags_t flags
);
  // Flags hold until software reloads them or the controller clears them.
  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      flags <= '0;
    end else if (set_en) begin
      flags <= set_val;
    end else begin
      flags.ext0_request_flag <= flags.ext0_request_flag & ~ext0_flag_clear;
      flags.ext1_request_flag <= flags.ext1_request_flag & ~ext1_flag_clear;
      flags.timer0_overflow_flag <= flags.timer0_overflow_flag & ~timer0_flag_clear;
      flags.timer1_overflow_flag <= flags.timer1_overflow_flag & ~timer1_flag_clear;
    end
  end
endmodule

// *** sim/ten_source_interrupt_controller_tb.sv ***
`timescale 1ns/1ps
`define CHK(n, g, e) chk(n, 20'(g), 20'(e))
module ten_source_interrupt_controller_tb;
  typedef struct packed {
    logic [31:0] regs;
    tsic_pkg::tsic_flags_t fl;
    logic [3:0] src;
    logic [15:0] vec;
  } tsic_row_t;
  // Register images are ordered extra enable, enable, extra level, level.
  localparam tsic_row_t ROWS [12] = '{
    '{32'h93BF0000, 14'h3FFF, 4'h0, 16'h0003}, '{32'h93BE0000, 14'h3FFF, 4'h1, 16'h004B},
    '{32'h93BF0000, 14'h0010, 4'h8, 16'h0023}, '{32'h93BF0000, 14'h0020, 4'h8, 16'h0023},
    '{32'h93BF0000, 14'h0040, 4'h9, 16'h002B}, '{32'h93BF0100, 14'h3FFF, 4'h7, 16'h0033},
    '{32'h93BF8000, 14'h3FFF, 4'h5, 16'h003B}, '{32'h93BF0200, 14'h3FFF, 4'h3, 16'h0043},
    '{32'h93BF0002, 14'h3FFF, 4'h2, 16'h000B}, '{32'h93BF0004, 14'h3FFF, 4'h4, 16'h0013},
    '{32'h93BF0008, 14'h3FFF, 4'h6, 16'h001B}, '{32'h93BF0000, 14'h2000, 4'h0, 16'h0003}
  };
  localparam logic [7:0] ADR [4] = '{8'hA7, 8'hA8, 8'hB7, 8'hB8};
  localparam logic [7:0] MSK [4] = '{8'h93, 8'hBF, 8'h93, 8'h3F};
  localparam logic [3:0] BLK [3] = '{4'h0, 4'hC, 4'h9};
  logic ref_clk = 1'b0, resetn = 1'b0, sfr_wr = 1'b0, set_en = 1'b0;
  logic [7:0] sfr_addr = 8'h00, sfr_wdata = 8'h00, sfr_rdata;
  tsic_pkg::tsic_core_t core = 4'h8;
  tsic_pkg::tsic_flags_t set_val = 14'h0000, flags;
  logic hw_vector_call, ext0_flag_clear, ext1_flag_clear, timer0_flag_clear, timer1_flag_clear;
  logic low_in_progress, high_in_progress, machine_cycle_start;
  logic [15:0] vector_addr;
  logic [3:0] vector_src;
  int error_cnt = 0, num_checks = 0, cyc = 0;
  tsic_ctrl uut (.*);
  tsic_core_model u_model (.*);
  always #5 ref_clk = ~ref_clk;
  task automatic chk(string n, logic [19:0] g, logic [19:0] e);
    num_checks++;
    if (g !== e) begin
      error_cnt++;
      $display("Error %s expected %0h seen %0h", n, e, g);
    end
  endtask
  task automatic wr(logic [7:0] a, logic [7:0] d);
    @(posedge ref_clk);
    sfr_addr <= a;
    sfr_wdata <= d;
    sfr_wr <= 1'b1;
    @(posedge ref_clk);
    sfr_wr <= 1'b0;
  endtask
  task automatic rd(logic [7:0] a, logic [7:0] e);
    @(posedge ref_clk);
    sfr_addr <= a;
    #1;
    `CHK("rdata", sfr_rdata, e);
  endtask
  task automatic setf(tsic_pkg::tsic_flags_t v);
    @(posedge ref_clk);
    set_val <= v;
    set_en <= 1'b1;
    @(posedge ref_clk);
    set_en <= 1'b0;
  endtask
  task automatic call(logic exp, logic [3:0] s, logic [15:0] v);
    logic got;
    got = 1'b0;
    for (int i = 0; i < 40 && !got; i++) begin
      @(posedge ref_clk);
      #1;
      got = (hw_vector_call === 1'b1);
    end
    `CHK("call", got, exp);
    if (got) `CHK("vector", {vector_src, vector_addr}, {s, v});
  endtask
  // Holds the return for exactly one machine cycle, so one poll sees it.
  task automatic ret(logic isr);
    @(posedge ref_clk);
    core.is_return_isr <= isr;
    core.is_plain_return <= !isr;
    repeat (12) @(posedge ref_clk);
    core <= 4'h8;
    @(posedge ref_clk);
    #1;
  endtask
  task automatic stop_test;
    $display("checks %0d mismatches %0d", num_checks, error_cnt);
    if (error_cnt == 0 && num_checks > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask
  always @(posedge ref_clk) begin
    cyc <= cyc + 1;
    if (cyc == 4000) begin
      error_cnt++;
      stop_test;
    end
  end
  initial begin
    repeat (4) @(posedge ref_clk);
    resetn <= 1'b1;
    foreach (ROWS[i]) begin
      foreach (ADR[k]) wr(ADR[k], ROWS[i].regs[31 - 8 * k -: 8]);
      setf(ROWS[i].fl);
      call(1'b1, ROWS[i].src, ROWS[i].vec);
      setf(14'h0000);
      ret(1'b1);
      `CHK("progress", {low_in_progress, high_in_progress}, 2'h0);
    end
    $display("table done");
    foreach (ADR[k]) begin
      wr(ADR[k], 8'hFF);
      rd(ADR[k], MSK[k]);
    end
    rd(8'hA9, 8'h00);
    $display("readback done");
    wr(8'hA8, 8'h3F);
    setf(14'h3FFF);
    call(1'b0, 4'h0, 16'h0000);
    foreach (BLK[k]) begin
      @(posedge ref_clk);
      core <= BLK[k];
      wr(8'hA8, 8'hBF);
      call(1'b0, 4'h0, 16'h0000);
    end
    setf(14'h0000);
    // Samples taken before the flags dropped may still be polled; let two cycles pass.
    repeat (24) @(posedge ref_clk);
    core <= 4'h8;
    call(1'b0, 4'h0, 16'h0000);
    $display("blocking done");
    wr(8'hB8, 8'h20);
    wr(8'hB7, 8'h00);
    setf(14'h0C00);
    call(1'b1, 4'h4, 16'h0013);
    @(posedge ref_clk);
    #1;
    `CHK("ext1 flag", flags.ext1_request_flag, 1'b0);
    setf(14'h0200);
    call(1'b0, 4'h0, 16'h0000);
    setf(14'h0280);
    call(1'b1, 4'h9, 16'h002B);
    setf(14'h2000);
    call(1'b0, 4'h0, 16'h0000);
    setf(14'h0000);
    ret(1'b0);
    `CHK("progress", {low_in_progress, high_in_progress}, 2'h3);
    ret(1'b1);
    `CHK("progress", {low_in_progress, high_in_progress}, 2'h2);
    ret(1'b1);
    `CHK("progress", {low_in_progress, high_in_progress}, 2'h0);
    $display("preemption done");
    @(posedge ref_clk);
    resetn <= 1'b0;
    repeat (4) @(posedge ref_clk);
    resetn <= 1'b1;
    foreach (ADR[k]) rd(ADR[k], 8'h00);
    $display("reset done");
    stop_test;
  end
endmodule
bind tsic_ctrl tsic_sva u_sva (.*);
